// file: logic/sar_readout.sv
// frame sequencing and serial result output of the dual converter
//
// Overview of operation
// R1 - frame runs from select fall to rise
// R2 - output floats while select high, else driven
// R3 - first three edges acquire both inputs
// R4 - twelve conversion cycles, one bit each
// R5 - edges 1-4 zeros, 5-16 channel A
// R6 - edges 17-20 zeros, 21-32 channel B
// R7 - continuous: reacquire after every 32 edges
// R8 - select falls, clock high: wait next fall
// R9 - select falls, clock low: acquire, edge one
// R10 - acquire, convert, sleep; sleep when deselected
// R11 - back-to-back 32-cycle conversions while selected
// R12 - host avoids select fall at clock rise
// R13 - host keeps serial clock 1.6 to 6.4 MHz
// R14 - results are 12-bit two's complement
// R15 - output changes only on clock falls
// R16 - host samples on next rise or fall
// R17 - early select rise aborts, output floats
// R18 - host clocks 32 times the sample rate
// R19 - burst mode: sleep after each conversion
// R20 - host may stop clock while deselected
// R21 - shifted bits belong to current conversion
// R22 - fall counter wraps at 32, picks phase
`timescale 1ns/1ps
`include "sar_readout_consts.svh"
module sar_readout
    import sar_readout_pkg::*;
(
    input wire logic clk, // system clock, 200 MHz
    input wire logic ce, // clock enable, freezes all state when low
    input wire logic rst_b, // synchronous reset, active low
    input wire logic csN, // frame select from host, active low
    input wire logic sclk, // serial clock from host, sampled
    input wire logic [`RESULT_BITS-1:0] chanA, // channel A input code
    input wire logic [`RESULT_BITS-1:0] chanB, // channel B input code
    output logic dout, // serial result bit
    output logic doutOeN, // output enable, low while driving
    output logic acquiring, // tracking the inputs
    output logic converting, // approximation in progress
    output logic asleep // powered down
);
    readout_state_t s_q, s_d;
    logic sclkFall, csFall, sample, step;
    logic [5:0] edgeNext;
    logic [1:0] bitNow;
    logic [1:0][`RESULT_BITS-1:0] chanIn, chanRes;

    assign chanIn[0] = chanA;
    assign chanIn[1] = chanB;

    // one core per channel, both sampled on the same edge
    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : gChan
            sar_channel uCore (
                .clk(clk),
                .ce(ce),
                .rst_b(rst_b),
                .analogIn(chanIn[g]),
                .sample(sample),
                .step(step),
                .bitOut(bitNow[g]),
                .result(chanRes[g])
            );
        end
    endgenerate

    function automatic logic inRange(logic [5:0] e, logic [5:0] lo,
                                     logic [5:0] hi);
        return (e >= lo) && (e <= hi);
    endfunction

    function automatic logic resultBit(logic [`RESULT_BITS-1:0] r,
                                       logic [5:0] e);
        logic [5:0] idx;
        idx = 6'(`EDGE_B_LAST - e);
        return r[idx[3:0]];
    endfunction

    assign sclkFall = s_q.sclkPrev & ~sclk;
    assign csFall = s_q.csPrevN & ~csN;
    // counter wraps after edge 32 back to edge 1
    assign edgeNext = (s_q.edgeCnt == `EDGE_B_LAST) ? `EDGE_FIRST :
                      6'(s_q.edgeCnt + 6'd1); // [R22] [R7] [R11]

    always_comb begin
        s_d = s_q;
        sample = 1'b0;
        step = 1'b0;
        s_d.sclkPrev = sclk;
        s_d.csPrevN = csN;
        if (csN) begin
            // deselected or aborted: float, sleep, clear counter
            s_d.phase = PH_SLEEP; // [R1] [R10] [R17]
            s_d.edgeCnt = `EDGE_NONE; // [R22]
            s_d.doutOeN = 1'b1; // [R2]
            s_d.dout = 1'b0;
        end else if (csFall) begin
            s_d.doutOeN = 1'b0; // [R2] [R1]
            s_d.dout = 1'b0;
            if (!sclk) begin
                s_d.phase = PH_ACQ; // [R9]
                s_d.edgeCnt = `EDGE_FIRST; // [R9]
            end else begin
                s_d.phase = PH_ARMED; // [R8]
                s_d.edgeCnt = `EDGE_NONE;
            end
        end else if (sclkFall && s_q.phase != PH_SLEEP) begin
            s_d.edgeCnt = edgeNext; // [R22]
            s_d.dout = 1'b0; // [R15] [R5] [R6]
            if (inRange(edgeNext, `EDGE_FIRST, `EDGE_ACQ_LAST)) begin
                s_d.phase = PH_ACQ; // [R3] [R7] [R8]
            end else if (edgeNext == `EDGE_CONV_START) begin
                s_d.phase = PH_CONV; // [R4] [R7]
                sample = 1'b1; // [R21]
            end else if (inRange(edgeNext, `EDGE_A_FIRST, `EDGE_A_LAST)) begin
                step = 1'b1; // [R4]
                s_d.dout = bitNow[0]; // [R5] [R14] [R21]
                s_d.phase = (edgeNext == `EDGE_A_LAST) ? PH_DONE : PH_CONV;
            end else if (inRange(edgeNext, `EDGE_B_FIRST, `EDGE_B_LAST)) begin
                s_d.dout = resultBit(chanRes[1], edgeNext); // [R6] [R21]
                s_d.phase = PH_DONE; // [R19]
            end else begin
                s_d.phase = PH_DONE; // [R6] [R10]
            end
        end
        s_d.acquiring = (s_d.phase == PH_ACQ);
        s_d.converting = (s_d.phase == PH_CONV);
        s_d.asleep = (s_d.phase == PH_SLEEP) || (s_d.phase == PH_DONE)
                     || (s_d.phase == PH_ARMED); // [R10]
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            s_q <= '0;
            s_q.phase <= PH_SLEEP;
            s_q.csPrevN <= 1'b1;
            s_q.doutOeN <= 1'b1;
            s_q.asleep <= 1'b1;
        end else if (ce) begin
            s_q <= s_d;
        end
    end

    assign dout = s_q.dout;
    assign doutOeN = s_q.doutOeN;
    assign acquiring = s_q.acquiring;
    assign converting = s_q.converting;
    assign asleep = s_q.asleep;

    // helper: expected channel codes captured at the sampling edge
    logic [`RESULT_BITS-1:0] refA_q;
    logic [`RESULT_BITS-1:0] refB_q;
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            refA_q <= '0;
            refB_q <= '0;
        end else if (ce && sample) begin
            refA_q <= chanA;
            refB_q <= chanB;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    sequence selFallLow;
        ce && csFall && !csN && !sclk;
    endsequence
    sequence firstAcq;
        acquiring && !doutOeN && s_q.edgeCnt == `EDGE_FIRST;
    endsequence

    output_float_a: assert property ( // [R2]
        (ce && csN) |=> doutOeN)
        else $error("output not floated while deselected");
    output_drive_a: assert property ( // [R2]
        (ce && !csN) |=> !doutOeN)
        else $error("output not driven while selected");
    start_low_a: assert property ( // [R9]
        selFallLow |=> firstAcq)
        else $error("no immediate acquisition on select fall");
    start_high_a: assert property ( // [R8]
        (ce && csFall && sclk) |=> (!acquiring && s_q.phase == PH_ARMED))
        else $error("acquisition started before clock fall");
    phase_map_a: assert property ( // [R3]
        (!doutOeN && inRange(s_q.edgeCnt, `EDGE_FIRST, `EDGE_ACQ_LAST))
        |-> acquiring)
        else $error("not acquiring during first three edges");
    pad_zero_a: assert property ( // [R5]
        (!doutOeN && (inRange(s_q.edgeCnt, `EDGE_FIRST, `EDGE_CONV_START)
        || inRange(s_q.edgeCnt, `EDGE_PAD_B_FIRST, `EDGE_PAD_B_LAST)))
        |-> !dout)
        else $error("padding bit not zero");
    fall_only_a: assert property ( // [R15]
        (!doutOeN && $past(!doutOeN) && $changed(dout)) |-> $past(sclkFall))
        else $error("output changed without clock fall");
    wrap_acq_a: assert property ( // [R7]
        (ce && !csN && !csFall && sclkFall
         && s_q.edgeCnt == `EDGE_B_LAST) |=> firstAcq)
        else $error("no reacquisition after edge 32");
    sleep_sel_a: assert property ( // [R10]
        (ce && csN) |=> (asleep && !acquiring && !converting))
        else $error("not asleep while deselected");
    result_a_a: assert property ( // [R21]
        (ce && step && edgeNext == `EDGE_A_LAST) |=> chanRes[0] == refA_q)
        else $error("channel A result not from this sample");

    sequence convEntry;
        converting && !acquiring && !asleep;
    endsequence
    sequence sleepDriven;
        asleep && !converting && !acquiring && !doutOeN;
    endsequence

    conv_start_a: assert property ( // [R4]
        (ce && !csN && !csFall && sclkFall && s_q.phase != PH_SLEEP
         && edgeNext == `EDGE_CONV_START) |=> convEntry)
        else $error("conversion not entered on fourth edge");
    burst_sleep_a: assert property ( // [R19]
        (ce && step && edgeNext == `EDGE_A_LAST) |=> sleepDriven)
        else $error("no power-down after last conversion step");
    result_b_a: assert property ( // [R21]
        (ce && step && edgeNext == `EDGE_A_LAST) |=> chanRes[1] == refB_q)
        else $error("channel B result not from this sample");
    abort_float_a: assert property ( // [R17]
        (ce && csN && !doutOeN) |=> (doutOeN && !dout && asleep))
        else $error("select rise did not abort and float");
endmodule

// file: logic/sar_readout_consts.svh
// edge numbers, widths and values for the dual-channel serial readout
`ifndef SAR_READOUT_CONSTS_SVH
`define SAR_READOUT_CONSTS_SVH
`define RESULT_BITS 12
`define EDGE_FIRST 6'd1
`define EDGE_ACQ_LAST 6'd3
`define EDGE_CONV_START 6'd4
`define EDGE_A_FIRST 6'd5
`define EDGE_A_LAST 6'd16
`define EDGE_PAD_B_FIRST 6'd17
`define EDGE_PAD_B_LAST 6'd20
`define EDGE_B_FIRST 6'd21
`define EDGE_B_LAST 6'd32
`define EDGE_NONE 6'd0
`define SAR_MSB_MASK 12'h800
`define SAR_ZERO 12'h000
`endif

// file: logic/sar_readout_pkg.sv
// types shared by the readout sequencer and the approximation core
`include "sar_readout_consts.svh"
package sar_readout_pkg;
    typedef enum logic [2:0] {
        PH_SLEEP = 3'b000,
        PH_ARMED = 3'b001,
        PH_ACQ = 3'b011,
        PH_CONV = 3'b010,
        PH_DONE = 3'b110
    } phase_t;

    typedef struct packed {
        phase_t phase;
        logic [5:0] edgeCnt;
        logic sclkPrev;
        logic csPrevN;
        logic dout;
        logic doutOeN;
        logic acquiring;
        logic converting;
        logic asleep;
    } readout_state_t;

    typedef struct packed {
        logic [`RESULT_BITS-1:0] held;
        logic [`RESULT_BITS-1:0] trial;
        logic [`RESULT_BITS-1:0] mask;
        logic [`RESULT_BITS-1:0] result;
    } sar_state_t;
endpackage

// file: logic/sar_channel.sv
// one successive-approximation channel, one decision per step
`timescale 1ns/1ps
`include "sar_readout_consts.svh"
module sar_channel
    import sar_readout_pkg::*;
(
    input wire logic clk, // system clock
    input wire logic ce, // clock enable
    input wire logic rst_b, // synchronous reset, active low
    input wire logic [`RESULT_BITS-1:0] analogIn, // two's complement input
    input wire logic sample, // hold the input, restart the search
    input wire logic step, // resolve one bit
    output logic bitOut, // bit resolved by the coming step
    output logic [`RESULT_BITS-1:0] result // finished two's complement code
);
    sar_state_t s_q, s_d;
    logic decide;

    // search runs in offset binary; the msb is inverted back on output
    assign decide = (s_q.held >= s_q.trial);
    assign bitOut = decide ^ s_q.mask[`RESULT_BITS-1];
    assign result = s_q.result;

    always_comb begin
        s_d = s_q;
        if (sample) begin
            s_d.held = analogIn ^ `SAR_MSB_MASK;
            s_d.trial = `SAR_MSB_MASK;
            s_d.mask = `SAR_MSB_MASK;
            s_d.result = `SAR_ZERO;
        end else if (step) begin
            s_d.result = {s_q.result[`RESULT_BITS-2:0], bitOut};
            s_d.trial = decide ? s_q.trial : (s_q.trial & ~s_q.mask);
            s_d.mask = s_q.mask >> 1;
            s_d.trial = s_d.trial | s_d.mask;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            s_q <= '0;
        end else if (ce) begin
            s_q <= s_d;
        end
    end
endmodule

// file: sim/host_serial_model.sv
// host serial controller that frames, clocks and captures the readout
`timescale 1ns/1ps
module host_serial_model (
    input wire logic clk, // system clock
    input wire logic doutPin, // resolved serial result line
    output logic csN, // frame select, active low
    output logic sclk, // serial clock, idles low
    output logic [63:0] captured // bits taken just before each rise
);
    localparam int HALF = 16; // 6.25 MHz serial clock

    initial begin
        csN = 1'b1;
        sclk = 1'b0;
        captured = 64'h0;
    end

    task automatic waitClk(input int n);
        repeat (n) @(negedge clk);
    endtask

    // select never falls with a rising clock edge
    task automatic frame(input int falls, input bit startHigh);
        captured = 64'h0;
        if (startHigh) begin
            sclk = 1'b1;
            waitClk(HALF);
        end
        csN = 1'b0;
        // clock stays high a half period after select falls
        if (startHigh) begin
            waitClk(HALF);
        end
        for (int i = 1; i <= falls; i++) begin
            if (i > 1 || startHigh) begin
                sclk = 1'b0;
            end
            waitClk(HALF);
            captured = {captured[62:0], doutPin};
            sclk = 1'b1;
            waitClk(HALF);
        end
        // raise select while clock is high, then park the clock
        csN = 1'b1;
        waitClk(HALF);
        sclk = 1'b0;
        waitClk(HALF);
    endtask
endmodule

// file: sim/sar_readout_test.sv
// self-checking bench for the dual-channel serial readout
`timescale 1ns/1ps
`include "sar_readout_consts.svh"
module sar_readout_test;
    logic clk, rst_b, ce, csN, sclk, dout, doutOeN;
    logic acquiring, converting, asleep;
    logic [`RESULT_BITS-1:0] chanA, chanB;
    logic [63:0] captured;
    wire doutPin;
    int fails, checked, acqCnt, convCnt, oeCnt;

    // pin floats whenever the output enable is high
    assign doutPin = doutOeN ? 1'bz : dout;

    sar_readout dut_u (.clk(clk), .ce(ce), .rst_b(rst_b), .csN(csN),
        .sclk(sclk), .chanA(chanA), .chanB(chanB), .dout(dout),
        .doutOeN(doutOeN), .acquiring(acquiring), .converting(converting),
        .asleep(asleep));
    host_serial_model host_u (.clk(clk), .doutPin(doutPin), .csN(csN),
        .sclk(sclk), .captured(captured));

    always #2.5 clk = ~clk;

    always @(posedge clk) begin
        if (acquiring === 1'b1) acqCnt++;
        if (converting === 1'b1) convCnt++;
        if (doutOeN === 1'b0) oeCnt++;
    end

    task automatic wrap_up;
        $display("comparisons %0d, mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic compare(input string what, input logic [63:0] exp,
            input logic [63:0] got);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask

    task automatic clearCounts;
        acqCnt = 0;
        convCnt = 0;
        oeCnt = 0;
    endtask

    task automatic single_frame(input logic [11:0] a, input logic [11:0] b,
            input bit high);
        chanA = a;
        chanB = b;
        clearCounts();
        host_u.frame(32, high);
        compare("frame bits", {32'h0, 4'h0, a, 4'h0, b},
            captured);
        compare("acquire cycles", 64'd96, 64'(acqCnt));
        compare("convert cycles", 64'd384, 64'(convCnt));
        compare("drive cycles", high ? 64'd1040 : 64'd1024,
            64'(oeCnt));
        compare("idle state", 64'h3, {doutOeN, asleep});
    endtask

    task automatic continuous(input logic [11:0] a1, input logic [11:0] b1,
            input logic [11:0] a2, input logic [11:0] b2);
        int n;
        chanA = a1;
        chanB = b1;
        clearCounts();
        fork
            host_u.frame(64, 1'b0);
            begin
                n = 0;
                while (converting !== 1'b1 && n < 2000) begin
                    @(negedge clk);
                    n++;
                end
                while (converting !== 1'b0 && n < 2000) begin
                    @(negedge clk);
                    n++;
                end
                if (n >= 2000) begin
                    fails++;
                    $display("unexpected convert wait: expected %0d, seen %0d",
                        1999, n);
                    wrap_up();
                end
                chanA = a2;
                chanB = b2;
            end
        join
        compare("stream bits", {4'h0, a1, 4'h0, b1, 4'h0, a2, 4'h0, b2},
            captured);
        compare("acquire cycles", 64'd192, 64'(acqCnt));
        compare("convert cycles", 64'd768, 64'(convCnt));
    endtask

    // select falls while frozen; the frame starts once the enable returns
    task automatic frozen_start;
        chanA = 12'h2b4;
        chanB = 12'hd4c;
        ce = 1'b0;
        fork
            host_u.frame(32, 1'b0);
            begin
                repeat (5) @(negedge clk);
                compare("frozen state", 64'h6,
                    {doutOeN, asleep, acquiring});
                ce = 1'b1;
            end
        join
        compare("late frame bits", {32'h0, 4'h0, 12'h2b4, 4'h0, 12'hd4c},
            captured);
    endtask

    task automatic aborted_frame;
        chanA = 12'h5a5;
        chanB = 12'ha5a;
        host_u.frame(10, 1'b0);
        compare("abort state", 64'h3, {doutOeN, asleep, acquiring,
            converting} >> 2);
        compare("abort busy", 64'h0, {acquiring, converting});
        single_frame(12'h123, 12'hedc, 1'b0);
    endtask

    initial begin
        clk = 1'b0;
        rst_b = 1'b0;
        ce = 1'b1;
        chanA = 12'h000;
        chanB = 12'h000;
        fails = 0;
        checked = 0;
        clearCounts();
        repeat (10) @(negedge clk);
        rst_b = 1'b1;
        compare("reset state", 64'h3, {doutOeN, asleep});
        single_frame(12'h7ff, 12'h800, 1'b0);
        single_frame(12'h001, 12'hfff, 1'b1);
        continuous(12'h7ff, 12'h000, 12'h800, 12'h3c1);
        frozen_start();
        aborted_frame();
        wrap_up();
    end
endmodule
